// [inc/pce_regs.svh]
// offsets, field positions and reset values of the crc engine and its controller
// assumes inclusion by bare name from the design files
`ifndef PCE_REGS_SVH
`define PCE_REGS_SVH

// engine register offsets on the link
`define PCE_DATA_OFS 5'h00
`define PCE_STAT_OFS 5'h04
`define PCE_CTRL_OFS 5'h08
`define PCE_INIT_OFS 5'h10
`define PCE_POLY_OFS 5'h14

// control fields
`define PCE_RESTART_BIT 0
`define PCE_DSIZE_LSB 1
`define PCE_PSIZE_LSB 3
`define PCE_RIN_LSB 5
`define PCE_ROUT_BIT 7

// status fields
`define PCE_DONE_BIT 0
`define PCE_OVF_BIT 1

// reset values
`define PCE_DATA_RST 32'h0FFFFFFF
`define PCE_INIT_RST 32'h0FFFFFFF
`define PCE_POLY_RST 32'h04C11DB7
`define PCE_DSIZE_RST 2'h3

// input reflection codes
`define PCE_RIN_NONE 2'h0
`define PCE_RIN_BYTE 2'h1
`define PCE_RIN_HALF 2'h2
`define PCE_RIN_WORD 2'h3

// polynomial widths and checksum masks
`define PCE_BITS32 32
`define PCE_BITS16 16
`define PCE_BITS8 8
`define PCE_BITS7 7
`define PCE_MASK32 32'hFFFFFFFF
`define PCE_MASK16 32'h0000FFFF
`define PCE_MASK8 32'h000000FF
`define PCE_MASK7 32'h0000007F

// controller wishbone offsets
`define PCE_WB_CMD 8'h00
`define PCE_WB_WDATA 8'h04
`define PCE_WB_RDATA 8'h08
`define PCE_WB_STAT 8'h0C
`define PCE_WB_IST 8'h10
`define PCE_WB_IMASK 8'h14

// controller fields
`define PCE_CMD_WE_BIT 8
`define PCE_IRQ_XFER_BIT 0
`define PCE_IRQ_OVF_BIT 1

`endif

// [inc/pce_pkg.sv]
// types shared by the crc engine, its controller and the link between them
// assumes nothing of its surroundings
package pce_pkg;
	typedef logic [4:0] pce_addr_t;
	typedef enum logic [1:0] {
		PCE_W32 = 2'h0,
		PCE_W16 = 2'h1,
		PCE_W8 = 2'h2,
		PCE_W7 = 2'h3
	} pce_width_t;
	typedef enum logic [1:0] {
		PCE_H_IDLE = 2'h0,
		PCE_H_POLL = 2'h1,
		PCE_H_ACC = 2'h3
	} pce_hstate_t;
endpackage

// [inc/pce_if.sv]
// register link between the crc engine and its controller
// assumes both ends share one clock; req is held until ack is seen
`timescale 1ns/1ps
interface pce_if;
	logic req;
	logic we;
	pce_pkg::pce_addr_t addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic ack;
	modport dev(input req, input we, input addr, input wdata, output rdata, output ack);
	modport host(output req, output we, output addr, output wdata, input rdata, input ack);
endinterface

// [verilog/pce_engine.sv]
// programmable crc engine: registers on the link, byte-serial checksum
// assumes a controller on the link that holds req until it sees ack
//
// Behaviour
// - hold polynomial, seed, width, count, reflection settings
// - width code selects 32/16/8/7 bits
// - one input byte per clock cycle
// - byte count selects bytes zero upward
// - bytes enter least significant first
// - bits of a byte enter msb first
// - input reflection by byte, half-word, word
// - optional bit-reversed checksum readout
// - no final xor applied
// - host configures, then restarts, then sends data
// - restart loads seed, bit clears itself
// - host writes data words back to back
// - host changes count only when done
// - host waits done before a short tail
// - done clears on data write, sets after
// - overflow when word arrives during calculation
// - host reads checksum, applies xor itself
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "pce_regs.svh"
module pce_engine (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// register link
	pce_if.dev bus,
	// status view
	output logic busy_o,
	output logic done_o,
	output logic ovf_o
);

	logic [31:0] crc;
	logic [31:0] poly;
	logic [31:0] init;
	logic [31:0] word;
	logic [31:0] rdata;
	pce_pkg::pce_width_t psize;
	logic [1:0] dsize;
	logic [1:0] rin;
	logic [1:0] bidx;
	logic rout;
	logic busy;
	logic done;
	logic ovf;
	logic ack;
	logic acc;
	logic wr;
	logic wr_data;
	logic wr_ctrl;
	logic restart;
	logic last_byte;
	logic [7:0] cur_byte;
	pce_pkg::pce_width_t new_psize;

	function automatic logic [31:0] wmask(input pce_pkg::pce_width_t s);
		logic [31:0] m;
		m = `PCE_MASK32;
		unique case (s)
			pce_pkg::PCE_W32: m = `PCE_MASK32;
			pce_pkg::PCE_W16: m = `PCE_MASK16;
			pce_pkg::PCE_W8: m = `PCE_MASK8;
			pce_pkg::PCE_W7: m = `PCE_MASK7;
		endcase
		return m;
	endfunction

	function automatic int wbits(input pce_pkg::pce_width_t s);
		int n;
		n = `PCE_BITS32;
		unique case (s)
			pce_pkg::PCE_W32: n = `PCE_BITS32;
			pce_pkg::PCE_W16: n = `PCE_BITS16;
			pce_pkg::PCE_W8: n = `PCE_BITS8;
			pce_pkg::PCE_W7: n = `PCE_BITS7;
		endcase
		return n;
	endfunction

	// one byte through the divider, msb first, feedback from the width's top bit
	function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d,
			input logic [31:0] p, input pce_pkg::pce_width_t s);
		logic [31:0] m;
		logic [31:0] t;
		logic [31:0] r;
		logic fb;
		m = wmask(s);
		t = m ^ (m >> 1);
		r = c & m;
		for (int i = 7; i >= 0; i--) begin
			fb = (|(r & t)) ^ d[i];
			r = ((r << 1) & m) ^ (fb ? (p & m) : 32'h0);
		end
		return r;
	endfunction

	function automatic logic [31:0] input_reflect_mode(input logic [31:0] w, input logic [1:0] mode);
		logic [31:0] r;
		r = w;
		for (int i = 0; i < 32; i++) begin
			unique case (mode)
				`PCE_RIN_NONE: r[i] = w[i];
				`PCE_RIN_BYTE: r[i] = w[(i & ~7) | (7 - (i & 7))];
				`PCE_RIN_HALF: r[i] = w[(i & ~15) | (15 - (i & 15))];
				`PCE_RIN_WORD: r[i] = w[31 - i];
			endcase
		end
		return r;
	endfunction

	// reflection spans only the selected width so the result stays in the low bits
	function automatic logic [31:0] out_view(input logic [31:0] c, input logic en,
			input pce_pkg::pce_width_t s);
		logic [31:0] r;
		int n;
		n = wbits(s);
		r = c & wmask(s);
		if (en) begin
			r = 32'h0;
			for (int i = 0; i < 32; i++) begin
				if (i < n) begin
					r[i] = c[n - 1 - i];
				end
			end
		end
		return r;
	endfunction

	assign acc = bus.req && !ack;
	assign wr = acc && bus.we;
	assign wr_data = wr && (bus.addr == `PCE_DATA_OFS);
	assign wr_ctrl = wr && (bus.addr == `PCE_CTRL_OFS);
	assign restart = wr_ctrl && bus.wdata[`PCE_RESTART_BIT];
	assign new_psize = pce_pkg::pce_width_t'(bus.wdata[`PCE_PSIZE_LSB +: 2]);
	assign cur_byte = 8'(word >> {bidx, 3'h0});
	assign last_byte = (bidx == dsize);

	// link answer: one cycle after the request is seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			rdata <= 32'h0;
		end else if (ce_i) begin
			ack <= acc;
			if (acc && !bus.we) begin
				unique case (bus.addr)
					`PCE_DATA_OFS: rdata <= out_view(crc, rout, psize);
					`PCE_STAT_OFS: begin
						rdata <= 32'h0;
						rdata[`PCE_DONE_BIT] <= done;
						rdata[`PCE_OVF_BIT] <= ovf;
					end
					`PCE_CTRL_OFS: begin
						rdata <= 32'h0;
						rdata[`PCE_ROUT_BIT] <= rout;
						rdata[`PCE_RIN_LSB +: 2] <= rin;
						rdata[`PCE_PSIZE_LSB +: 2] <= psize;
						rdata[`PCE_DSIZE_LSB +: 2] <= dsize;
					end
					`PCE_INIT_OFS: rdata <= init;
					`PCE_POLY_OFS: rdata <= poly;
					default: rdata <= 32'h0;
				endcase
			end
		end
	end

	// configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rout <= 1'b0;
			rin <= `PCE_RIN_NONE;
			psize <= pce_pkg::PCE_W32;
			dsize <= `PCE_DSIZE_RST;
			init <= `PCE_INIT_RST;
			poly <= `PCE_POLY_RST;
		end else if (ce_i) begin
			if (wr_ctrl) begin
				rout <= bus.wdata[`PCE_ROUT_BIT];
				rin <= bus.wdata[`PCE_RIN_LSB +: 2];
				psize <= new_psize;
				dsize <= bus.wdata[`PCE_DSIZE_LSB +: 2];
			end
			if (wr && bus.addr == `PCE_INIT_OFS) begin
				init <= bus.wdata;
			end
			if (wr && bus.addr == `PCE_POLY_OFS) begin
				poly <= bus.wdata;
			end
		end
	end

	// running checksum
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crc <= `PCE_DATA_RST;
		end else if (ce_i) begin
			if (restart) begin
				crc <= init & wmask(new_psize);
			end else if (busy) begin
				crc <= step(crc, cur_byte, poly, psize);
			end
		end
	end

	// byte sequencer: a new word restarts at byte zero, dropping any unsent bytes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy <= 1'b0;
			bidx <= 2'h0;
			word <= 32'h0;
		end else if (ce_i) begin
			if (restart) begin
				busy <= 1'b0;
				bidx <= 2'h0;
			end else if (wr_data) begin
				busy <= 1'b1;
				bidx <= 2'h0;
				word <= input_reflect_mode(bus.wdata, rin);
			end else if (busy) begin
				if (last_byte) begin
					busy <= 1'b0;
				end else begin
					bidx <= bidx + 2'h1;
				end
			end
		end
	end

	// done and overflow flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done <= 1'b0;
			ovf <= 1'b0;
		end else if (ce_i) begin
			if (wr_data) begin
				done <= 1'b0;
			end else if (restart || (busy && last_byte)) begin
				done <= 1'b1;
			end
			if (restart) begin
				ovf <= 1'b0;
			end else if (wr_data && busy && !last_byte) begin
				ovf <= 1'b1;
			end
		end
	end

	assign bus.ack = ack;
	assign bus.rdata = rdata;
	assign busy_o = busy;
	assign done_o = done;
	assign ovf_o = ovf;

endmodule

// [verilog/pce_host.sv]
// controller for the crc engine: wishbone slave that runs link accesses
// assumes a classic wishbone master and the engine on the far end of the link
`timescale 1ns/1ps
`include "pce_regs.svh"
module pce_host (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// interrupt
	output logic irq_o,
	// link to the engine
	pce_if.host dev
);

	pce_pkg::pce_hstate_t state;
	pce_pkg::pce_addr_t cmd_addr;
	pce_pkg::pce_addr_t daddr;
	logic cmd_we;
	logic dwe;
	logic dreq;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [1:0] ist;
	logic [1:0] imask;
	logic [1:0] ev;
	logic wb_acc;
	logic wb_wr;
	logic start;
	logic [31:0] bmask;
	logic sent;
	logic ctl_wait;

	assign wb_acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_acc && wb_we_i;
	assign start = wb_wr && wb_adr_i == `PCE_WB_CMD && state == pce_pkg::PCE_H_IDLE;
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	// the engine leaves reset with done low and no word in flight, so polling is only
	// needed once a data word has gone out; otherwise the first restart would wait for ever
	assign ctl_wait = start && sent && wb_dat_i[`PCE_CMD_WE_BIT] &&
		wb_dat_i[4:0] == `PCE_CTRL_OFS;

	// events of this cycle
	always_comb begin
		ev = 2'h0;
		if (dev.ack && state == pce_pkg::PCE_H_ACC) begin
			ev[`PCE_IRQ_XFER_BIT] = 1'b1;
		end
		if (dev.ack && !dwe && daddr == `PCE_STAT_OFS) begin
			ev[`PCE_IRQ_OVF_BIT] = dev.rdata[`PCE_OVF_BIT];
		end
	end

	// link sequencer; once a data word has been sent, a control write first polls until the engine is done
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= pce_pkg::PCE_H_IDLE;
			dreq <= 1'b0;
			dwe <= 1'b0;
			daddr <= `PCE_DATA_OFS;
			rdata <= 32'h0;
		end else if (ce_i) begin
			unique case (state)
				pce_pkg::PCE_H_IDLE: begin
					if (ctl_wait) begin
						state <= pce_pkg::PCE_H_POLL;
						daddr <= `PCE_STAT_OFS;
						dwe <= 1'b0;
						dreq <= 1'b1;
					end else if (start) begin
						state <= pce_pkg::PCE_H_ACC;
						daddr <= wb_dat_i[4:0];
						dwe <= wb_dat_i[`PCE_CMD_WE_BIT];
						dreq <= 1'b1;
					end
				end
				pce_pkg::PCE_H_POLL: begin
					if (dev.ack && dev.rdata[`PCE_DONE_BIT]) begin
						state <= pce_pkg::PCE_H_ACC;
						daddr <= cmd_addr;
						dwe <= cmd_we;
					end
				end
				pce_pkg::PCE_H_ACC: begin
					if (dev.ack) begin
						state <= pce_pkg::PCE_H_IDLE;
						dreq <= 1'b0;
						rdata <= dev.rdata;
					end
				end
				default: begin
					state <= pce_pkg::PCE_H_IDLE;
					dreq <= 1'b0;
				end
			endcase
		end
	end

	// remembers that a data word has been sent since reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sent <= 1'b0;
		end else if (ce_i) begin
			if (dreq && dwe && daddr == `PCE_DATA_OFS) begin
				sent <= 1'b1;
			end
		end
	end

	// software-visible registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_addr <= `PCE_DATA_OFS;
			cmd_we <= 1'b0;
			wdata <= 32'h0;
			imask <= 2'h0;
		end else if (ce_i) begin
			if (start) begin
				cmd_addr <= wb_dat_i[4:0];
				cmd_we <= wb_dat_i[`PCE_CMD_WE_BIT];
			end
			// wdata is frozen while a link access may still read it
			if (wb_wr && wb_adr_i == `PCE_WB_WDATA && state == pce_pkg::PCE_H_IDLE) begin
				wdata <= (wdata & ~bmask) | (wb_dat_i & bmask);
			end
			if (wb_wr && wb_adr_i == `PCE_WB_IMASK && wb_sel_i[0]) begin
				imask <= wb_dat_i[1:0];
			end
		end
	end

	// sticky events, write one to clear, a new event beats the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ist <= 2'h0;
		end else if (ce_i) begin
			if (wb_wr && wb_adr_i == `PCE_WB_IST && wb_sel_i[0]) begin
				ist <= (ist & ~wb_dat_i[1:0]) | ev;
			end else begin
				ist <= ist | ev;
			end
		end
	end

	// wishbone answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else if (ce_i) begin
			wb_ack_o <= wb_acc;
			if (wb_acc && !wb_we_i) begin
				unique case (wb_adr_i)
					`PCE_WB_CMD: wb_dat_o <= {23'h0, cmd_we, 3'h0, cmd_addr};
					`PCE_WB_WDATA: wb_dat_o <= wdata;
					`PCE_WB_RDATA: wb_dat_o <= rdata;
					`PCE_WB_STAT: wb_dat_o <= {31'h0, state != pce_pkg::PCE_H_IDLE};
					`PCE_WB_IST: wb_dat_o <= {30'h0, ist};
					`PCE_WB_IMASK: wb_dat_o <= {30'h0, imask};
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	assign irq_o = |(ist & imask);
	assign dev.req = dreq;
	assign dev.we = dwe;
	assign dev.addr = daddr;
	assign dev.wdata = wdata;

endmodule

// [bench/pce_link_props.sv]
// concurrent checks on the link between the crc engine and its controller
// assumes one clock and the engine status outputs wired in beside the link
`timescale 1ns/1ps
`include "pce_regs.svh"
module pce_link_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// link
	input wire logic req,
	input wire logic we,
	input wire pce_pkg::pce_addr_t addr,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	input wire logic ack,
	// engine status
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic ovf_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic take, take_dat, take_ctl, rst_cmd, clean, rd_dat;
	logic [1:0] cnt_q, wid_q;
	logic [3:0] blen;
	logic [31:0] mask;
	assign take = req && !ack;
	assign take_dat = take && we && addr == `PCE_DATA_OFS;
	assign take_ctl = take && we && addr == `PCE_CTRL_OFS;
	assign rst_cmd = take_ctl && wdata[`PCE_RESTART_BIT];
	always_comb begin
		case (wid_q)
			2'h0: mask = `PCE_MASK32;
			2'h1: mask = `PCE_MASK16;
			2'h2: mask = `PCE_MASK8;
			default: mask = `PCE_MASK7;
		endcase
	end
	// shadow of the count and width, so word length and read masking can be judged
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= `PCE_DSIZE_RST;
			wid_q <= 2'h0;
		end else if (take_ctl) begin
			cnt_q <= wdata[`PCE_DSIZE_LSB +: 2];
			wid_q <= wdata[`PCE_PSIZE_LSB +: 2];
		end
	end
	// a word that lands on a busy engine runs longer, so only clean starts are timed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clean <= 1'b0;
		end else if (take_dat) begin
			clean <= !busy_o;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blen <= 4'h0;
		end else begin
			blen <= busy_o ? blen + 4'h1 : 4'h0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_dat <= 1'b0;
		end else begin
			rd_dat <= take && !we && addr == `PCE_DATA_OFS;
		end
	end
	a_ack_follows: assert property (take |=> ack)
		else $error("link ack missing after request");
	a_ack_pulse: assert property (ack |=> !ack)
		else $error("link ack longer than one cycle");
	a_ack_cause: assert property (ack |-> $past(take))
		else $error("link ack without request");
	a_done_clears: assert property (take_dat |=> !done_o && busy_o)
		else $error("done not cleared by data write");
	a_word_length: assert property ($fell(busy_o) && clean |-> blen == {2'h0, cnt_q} + 4'h1)
		else $error("word took wrong number of cycles");
	a_done_at_end: assert property ($fell(busy_o) |-> done_o)
		else $error("done not set when bytes finished");
	a_restart_state: assert property (rst_cmd |=> done_o && !ovf_o && !busy_o)
		else $error("restart did not reset status");
	a_ovf_cause: assert property ($rose(ovf_o) |-> $past(take_dat) && $past(busy_o))
		else $error("overflow without write during calculation");
	a_ovf_sticky: assert property (ovf_o && !rst_cmd |=> ovf_o)
		else $error("overflow dropped without restart");
	a_upper_zero: assert property (rd_dat |-> (rdata & ~mask) == 32'h0)
		else $error("unused checksum bits not zero");
	c_restart: cover property (rst_cmd);
	c_short_word: cover property ($fell(busy_o) && clean && cnt_q == 2'h0);
	c_narrow_read: cover property (rd_dat && wid_q == 2'h3);
	c_overflow: cover property ($rose(ovf_o));
endmodule

// [bench/programmable_crc_engine_tb_top.sv]
// self-checking bench: wishbone master drives the controller, which drives the crc engine
// assumes the package, interface, both design ends and the link checker are compiled first
`timescale 1ns/1ps
`include "pce_regs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
	$display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module programmable_crc_engine_tb_top;
	logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
	logic busy_o, done_o, ovf_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	int n_fail, check_count;
	pce_if bus ();
	pce_engine i_pce_engine (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus(bus.dev),
		.busy_o(busy_o), .done_o(done_o), .ovf_o(ovf_o));
	pce_host i_pce_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
		.dev(bus.host));
	pce_link_props i_pce_link_props (.clk_i(clk_i), .rst_i(rst_i), .req(bus.req), .we(bus.we),
		.addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack),
		.busy_o(busy_o), .done_o(done_o), .ovf_o(ovf_o));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic tally_and_finish();
		if (n_fail == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ack is sampled at the rising edge, data taken and the request released at that edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 200);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, q);
	endtask
	task automatic hwait();
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			rd(`PCE_WB_STAT, q);
			n++;
		end while (q[0] !== 1'b0 && n < 50);
		if (q[0] !== 1'b0) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	task automatic ewr(input pce_pkg::pce_addr_t a, input logic [31:0] d);
		wr(`PCE_WB_WDATA, d);
		wr(`PCE_WB_CMD, 32'(a) | (32'h1 << `PCE_CMD_WE_BIT));
		hwait();
	endtask
	task automatic erd(input pce_pkg::pce_addr_t a, output logic [31:0] q);
		wr(`PCE_WB_CMD, 32'(a));
		hwait();
		rd(`PCE_WB_RDATA, q);
	endtask
	task automatic edone();
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			erd(`PCE_STAT_OFS, q);
			n++;
		end while (q[`PCE_DONE_BIT] !== 1'b1 && n < 20);
		if (q[`PCE_DONE_BIT] !== 1'b1) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	function automatic int ref_bits(input logic [1:0] ws);
		case (ws)
			2'h0: return 32;
			2'h1: return 16;
			2'h2: return 8;
			default: return 7;
		endcase
	endfunction
	function automatic logic [31:0] ref_mask(input logic [1:0] ws);
		return (ws == 2'h0) ? 32'hFFFFFFFF : (32'h1 << ref_bits(ws)) - 32'h1;
	endfunction
	function automatic logic [31:0] ref_view(input logic [31:0] c, input logic [1:0] ws,
		input logic ro);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < ref_bits(ws); i++) begin
			r[i] = c[ref_bits(ws) - 1 - i];
		end
		return ro ? r : c & ref_mask(ws);
	endfunction
	// bitwise msb-first model, slow but independent of any table the design may hold
	function automatic logic [31:0] crc_run(input logic [31:0] c, input logic [31:0] word,
		input logic [31:0] p, input logic [1:0] ws, input logic [1:0] rin, input logic [1:0] cnt);
		logic [31:0] w;
		logic fb;
		for (int i = 0; i < 32; i++) begin
			case (rin)
				2'h1: w[i] = word[(i / 8) * 8 + 7 - i % 8];
				2'h2: w[i] = word[(i / 16) * 16 + 15 - i % 16];
				2'h3: w[i] = word[31 - i];
				default: w[i] = word[i];
			endcase
		end
		for (int b = 0; b <= cnt; b++) begin
			for (int k = 7; k >= 0; k--) begin
				fb = c[ref_bits(ws) - 1] ^ w[b * 8 + k];
				c = (c << 1) & ref_mask(ws);
				if (fb) begin
					c = c ^ (p & ref_mask(ws));
				end
			end
		end
		return c;
	endfunction
	task automatic t_reset();
		pce_pkg::pce_addr_t oa [6] = '{`PCE_DATA_OFS, `PCE_INIT_OFS, `PCE_POLY_OFS,
			`PCE_CTRL_OFS, 5'h1C, `PCE_STAT_OFS};
		logic [31:0] ev [6] = '{`PCE_DATA_RST, `PCE_INIT_RST, `PCE_POLY_RST,
			32'(`PCE_DSIZE_RST) << `PCE_DSIZE_LSB, 32'h0, 32'h0};
		logic [31:0] q;
		for (int i = 0; i < 6; i++) begin
			erd(oa[i], q);
			`CHK(q, ev[i])
		end
		rd(8'h20, q);
		`CHK(q, 32'h0)
		`CHK(irq_o, 1'b0)
	endtask
	// two data commands back to back land on a word that is still being processed
	task automatic t_ovf();
		logic [31:0] q;
		ewr(`PCE_CTRL_OFS, 32'h7);
		wr(`PCE_WB_IST, 32'h3);
		wr(`PCE_WB_IMASK, 32'h2);
		wr(`PCE_WB_WDATA, 32'h12345678);
		wr(`PCE_WB_CMD, 32'(`PCE_DATA_OFS) | (32'h1 << `PCE_CMD_WE_BIT));
		wr(`PCE_WB_CMD, 32'(`PCE_DATA_OFS) | (32'h1 << `PCE_CMD_WE_BIT));
		hwait();
		edone();
		erd(`PCE_STAT_OFS, q);
		`CHK(q, 32'h3)
		`CHK(irq_o, 1'b1)
		ewr(`PCE_CTRL_OFS, 32'h7);
		erd(`PCE_STAT_OFS, q);
		`CHK(q, 32'h1)
		wr(`PCE_WB_IMASK, 32'h0);
	endtask
	// with the clock enable low a pending access must stay unanswered
	task automatic t_ce();
		logic [31:0] q;
		int n;
		@(posedge clk_i);
		ce_i <= 1'b0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= 1'b1;
		wb_adr_i <= `PCE_WB_IMASK;
		wb_sel_i <= 4'hF;
		wb_dat_i <= 32'h3;
		repeat (4) @(posedge clk_i);
		`CHK(wb_ack_o, 1'b0)
		ce_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			n_fail++;
			tally_and_finish();
		end
		rd(`PCE_WB_IMASK, q);
		`CHK(q, 32'h3)
		wr(`PCE_WB_IMASK, 32'h0);
	endtask
	task automatic t_crc();
		logic [31:0] q, c, poly, seed, ctl;
		logic [1:0] ws, rin, cnt;
		logic ro;
		for (int i = 0; i < 8; i++) begin
			ws = 2'(i);
			rin = 2'(i / 2);
			cnt = 2'(3 - i);
			ro = i[0] ^ i[2];
			poly = (ws == 2'h0) ? 32'h04C11DB7 : (ws == 2'h1) ? 32'h00001021 :
				(ws == 2'h2) ? 32'h00000007 : 32'h00000009;
			seed = 32'hC3D2E1F0 ^ 32'(i);
			ctl = {24'h0, ro, rin, ws, cnt, 1'b0};
			ewr(`PCE_POLY_OFS, poly);
			ewr(`PCE_INIT_OFS, seed);
			ewr(`PCE_CTRL_OFS, ctl | 32'h1);
			erd(`PCE_CTRL_OFS, q);
			`CHK(q, ctl)
			c = seed & ref_mask(ws);
			erd(`PCE_DATA_OFS, q);
			`CHK(q, ref_view(c, ws, ro))
			ewr(`PCE_DATA_OFS, 32'h12345678);
			ewr(`PCE_DATA_OFS, 32'h9ABCDEF0);
			c = crc_run(c, 32'h12345678, poly, ws, rin, cnt);
			c = crc_run(c, 32'h9ABCDEF0, poly, ws, rin, cnt);
			edone();
			erd(`PCE_DATA_OFS, q);
			`CHK(q, ref_view(c, ws, ro))
			erd(`PCE_STAT_OFS, q);
			`CHK(q, 32'h1)
		end
	endtask
	task automatic t_irq();
		logic [31:0] q;
		wr(`PCE_WB_IST, 32'h3);
		wr(`PCE_WB_IMASK, 32'h1);
		erd(`PCE_STAT_OFS, q);
		`CHK(irq_o, 1'b1)
		wr(`PCE_WB_IST, 32'h1);
		`CHK(irq_o, 1'b0)
		rd(`PCE_WB_IST, q);
		`CHK(q[0], 1'b0)
		wr(`PCE_WB_IMASK, 32'h0);
		erd(`PCE_STAT_OFS, q);
		rd(`PCE_WB_IST, q);
		`CHK(q[0], 1'b1)
		`CHK(irq_o, 1'b0)
	endtask
	initial begin
		n_fail = 0;
		check_count = 0;
		rst_i = 1'b1;
		ce_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_crc();
		t_ovf();
		t_irq();
		t_ce();
		tally_and_finish();
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		n_fail++;
		tally_and_finish();
	end
endmodule
